// File: core/ipc_pkg.sv
package ipc_pkg;
  // Link widths, all within the defined maxima
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;
  localparam int LANE_W = 2;
  localparam int BYTE_W = 8;
  localparam int PLEN_W = 9;
  localparam int CLEN_W = 8;
  localparam int ID_W   = 8;
  localparam int TRD_W  = 4;
  localparam int LEN_W  = 16;
  localparam int STR_W  = 8;
  localparam int TMO_W  = 16;
  localparam int WAIT_W = 8;

  // Buffer and target storage
  localparam int FIFO_DEPTH = 8;
  localparam int MEM_WORDS  = 64;

  // Commands
  localparam logic [1:0] CMD_READ  = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;

  // Walk constants
  localparam logic [LANE_W-1:0] LAST_LANE  = 2'h3;
  localparam logic [BE_W-1:0]   BE_ONE     = 4'h1;
  localparam logic [LEN_W-1:0]  LEN_ONE    = 16'h0001;
  localparam logic [PLEN_W-1:0] PLEN_ONE   = 9'h001;
  localparam logic [STR_W-1:0]  STR_CELL   = 8'h04;
  localparam logic [ADDR_W-1:0] CELL_BYTES = 32'h00000004;

  typedef enum logic [1:0] {ST_IDLE, ST_BUILD, ST_SEND} ipc_ini_st_t;
endpackage

// File: core/ipc_link_if.sv
`timescale 1ns/1ps
interface ipc_link_if;
  // Request
  logic                        cmdval;
  logic                        cmdack;
  logic [1:0]                  cmd;
  logic [ipc_pkg::ADDR_W-1:0]  address;
  logic [ipc_pkg::BE_W-1:0]    be;
  logic [ipc_pkg::DATA_W-1:0]  wdata;
  logic [ipc_pkg::DATA_W-1:0]  exp_data;
  logic                        eop;
  logic [ipc_pkg::PLEN_W-1:0]  plen;
  logic [ipc_pkg::CLEN_W-1:0]  clen;
  logic                        contig;
  logic                        wrap;
  logic [ipc_pkg::ID_W-1:0]    srcid;
  logic [ipc_pkg::TRD_W-1:0]   trdid;
  logic [ipc_pkg::ID_W-1:0]    pktid;
  logic [ipc_pkg::STR_W-1:0]   str_step;
  logic [ipc_pkg::STR_W-1:0]   str_vlen;
  // Response
  logic                        rspval;
  logic                        rspack;
  logic [ipc_pkg::DATA_W-1:0]  rdata;
  logic                        reop;
  logic                        rerror;

  modport ini (
    output cmdval, cmd, address, be, wdata, exp_data, eop, plen, clen,
    output contig, wrap, srcid, trdid, pktid, str_step, str_vlen, rspack,
    input  cmdack, rspval, rdata, reop, rerror
  );
  modport tgt (
    input  cmdval, cmd, address, be, wdata, exp_data, eop, plen, clen,
    input  contig, wrap, srcid, trdid, pktid, str_step, str_vlen, rspack,
    output cmdack, rspval, rdata, reop, rerror
  );
endinterface

// File: core/ipc_fifo.sv
`timescale 1ns/1ps
module ipc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wp_r;
  logic [PW:0]      rp_r;
  logic             push;
  logic             pop;

  // Depth must be a power of two
  assign in_ready  = !((wp_r[PW-1:0] == rp_r[PW-1:0]) && (wp_r[PW] != rp_r[PW]));
  assign out_valid = wp_r != rp_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rp_r[PW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_r[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

// File: core/ipc_initiator.sv
`timescale 1ns/1ps
module ipc_initiator #(
  parameter bit                  default_ack_supported = 1'b0,
  parameter bit                  STRIDE_PATTERN_EN     = 1'b0,
  parameter int                  TIMEOUT_CYC           = 1024,
  parameter logic [7:0]          SRC_ID                = 8'h01
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  // Transfer request
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic                        req_read,
  input  wire logic [ipc_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [ipc_pkg::LEN_W-1:0]   req_tlen,
  input  wire logic [ipc_pkg::STR_W-1:0]   req_stride,
  input  wire logic [ipc_pkg::STR_W-1:0]   req_vlen,
  input  wire logic [ipc_pkg::PLEN_W-1:0]  req_plen,
  // Packed write bytes
  input  wire logic                        wr_valid,
  output logic                             wr_ready,
  input  wire logic [ipc_pkg::BYTE_W-1:0]  wr_byte,
  // Read return
  output logic                             rd_valid,
  output logic [ipc_pkg::DATA_W-1:0]       rd_data,
  output logic                             rd_last,
  output logic                             rd_err,
  // Status
  output logic                             done,
  output logic                             tmo_err,
  // Link
  ipc_link_if.ini                          lnk
);
  import ipc_pkg::*;

  ipc_ini_st_t        st_r;
  logic               rd_r;
  logic [STR_W-1:0]   stride_r;
  logic [STR_W-1:0]   vlen_r;
  logic [PLEN_W-1:0]  plenmax_r;
  logic [LEN_W-1:0]   left_r;
  logic [PLEN_W-1:0]  pk_rem_r;
  logic [PLEN_W-1:0]  pk_len_r;
  logic [LANE_W-1:0]  lane_r;
  logic [ADDR_W-1:0]  cadr_r;
  logic [STR_W-1:0]   ph_r;
  logic [ID_W-1:0]    pktid_r;
  logic [BE_W-1:0]    be_r;
  logic [DATA_W-1:0]  wd_r;
  logic               eop_r;
  logic [TMO_W-1:0]   tmo_r;
  logic               done_r;
  logic               tmo_err_r;
  logic               rd_valid_r;
  logic [DATA_W-1:0]  rd_data_r;
  logic               rd_last_r;
  logic               rd_err_r;

  logic               fb_valid;
  logic               fb_pop;
  logic [BYTE_W-1:0]  fb_byte;
  logic               start;
  logic               build;
  logic               en;
  logic               need;
  logic               stall;
  logic               last_byte;
  logic               pk_end;
  logic               cell_end;
  logic               skip;
  logic [BE_W-1:0]    be_now;
  logic [STR_W-1:0]   ph_inc;
  logic               acked;
  logic               tmo_hit;

  // Bytes of the next packet: rest of transfer, capped at the maximum
  function automatic logic [PLEN_W-1:0] pk_size(input logic [LEN_W-1:0]  left,
                                                input logic [PLEN_W-1:0] pmax);
    logic [LEN_W-1:0] wide;
    wide = {{(LEN_W-PLEN_W){1'b0}}, pmax};
    pk_size = (left < wide) ? left[PLEN_W-1:0] : pmax;
  endfunction

  ipc_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wbuf (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_byte),
    .out_valid (fb_valid),
    .out_ready (fb_pop),
    .out_data  (fb_byte)
  );

  // Zero length or zero packet size is dropped
  assign start     = st_r == ST_IDLE && req_valid && req_tlen != '0 && req_plen != '0;
  assign req_ready = st_r == ST_IDLE;
  assign build     = st_r == ST_BUILD;
  assign en        = stride_r == '0 || ph_r < vlen_r;
  assign need      = build && en && !rd_r;
  assign stall     = need && !fb_valid;
  assign fb_pop    = need && fb_valid;
  assign last_byte = left_r == LEN_ONE;
  assign pk_end    = pk_rem_r == PLEN_ONE;
  assign cell_end  = lane_r == LAST_LANE || last_byte || pk_end;
  assign be_now    = en ? (be_r | (BE_ONE << lane_r)) : be_r;
  assign skip      = be_now == '0 && !last_byte && !pk_end;
  assign ph_inc    = ph_r + 1'b1;
  // Ack may come in the cycle of the request when the target offers it
  assign acked     = st_r == ST_SEND && lnk.cmdack;
  assign tmo_hit   = st_r == ST_SEND && !lnk.cmdack && tmo_r == TMO_W'(TIMEOUT_CYC - 1);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (start) begin
            st_r <= ST_BUILD;
          end
        end
        ST_BUILD: begin
          if (!stall && cell_end && !skip) begin
            st_r <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (tmo_hit) begin
            st_r <= ST_IDLE;
          end else if (acked) begin
            st_r <= (eop_r && left_r == '0) ? ST_IDLE : ST_BUILD;
          end
        end
      endcase
    end
  end

  // Channel setup held for the whole chain
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_r      <= 1'b0;
      stride_r  <= '0;
      vlen_r    <= '0;
      plenmax_r <= '0;
    end else if (start) begin
      rd_r      <= req_read;
      stride_r  <= req_stride;
      vlen_r    <= req_vlen;
      plenmax_r <= req_plen;
    end
  end

  // Byte walk over the target address space
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      left_r   <= '0;
      pk_rem_r <= '0;
      pk_len_r <= '0;
      lane_r   <= '0;
      cadr_r   <= '0;
      ph_r     <= '0;
      pktid_r  <= '0;
    end else if (start) begin
      left_r   <= req_tlen;
      pk_rem_r <= pk_size(req_tlen, req_plen);
      pk_len_r <= pk_size(req_tlen, req_plen);
      lane_r   <= req_addr[LANE_W-1:0];
      cadr_r   <= {req_addr[ADDR_W-1:LANE_W], {LANE_W{1'b0}}};
      ph_r     <= '0;
      pktid_r  <= '0;
    end else if (build && !stall) begin
      left_r   <= left_r - 1'b1;
      pk_rem_r <= pk_rem_r - 1'b1;
      lane_r   <= lane_r + 1'b1;
      if (stride_r == '0 || ph_inc == stride_r) begin
        ph_r <= '0;
      end else begin
        ph_r <= ph_inc;
      end
      if (cell_end && skip) begin
        cadr_r <= cadr_r + CELL_BYTES;
      end
    end else if (acked) begin
      if (lane_r == '0) begin
        cadr_r <= cadr_r + CELL_BYTES;
      end
      if (eop_r && left_r != '0) begin
        pk_rem_r <= pk_size(left_r, plenmax_r);
        pk_len_r <= pk_size(left_r, plenmax_r);
        pktid_r  <= pktid_r + 1'b1;
      end
    end
  end

  // Cell assembly from packed source bytes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      be_r  <= '0;
      wd_r  <= '0;
      eop_r <= 1'b0;
    end else if (start) begin
      be_r <= '0;
      wd_r <= '0;
    end else if (build && !stall) begin
      be_r <= (cell_end && skip) ? '0 : be_now;
      if (fb_pop) begin
        wd_r[lane_r*BYTE_W +: BYTE_W] <= fb_byte;
      end
      if (cell_end) begin
        eop_r <= last_byte || pk_end;
      end
    end else if (acked) begin
      be_r <= '0;
      wd_r <= '0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tmo_r <= '0;
    end else if (st_r != ST_SEND || acked) begin
      tmo_r <= '0;
    end else begin
      tmo_r <= tmo_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      done_r    <= 1'b0;
      tmo_err_r <= 1'b0;
    end else begin
      done_r    <= acked && eop_r && left_r == '0;
      tmo_err_r <= tmo_hit;
    end
  end

  // Responses always taken
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid_r <= 1'b0;
      rd_data_r  <= '0;
      rd_last_r  <= 1'b0;
      rd_err_r   <= 1'b0;
    end else begin
      rd_valid_r <= lnk.rspval;
      if (lnk.rspval) begin
        rd_data_r <= lnk.rdata;
        rd_last_r <= lnk.reop;
        rd_err_r  <= lnk.rerror;
      end
    end
  end

  // Request fields come from registers frozen in the send state, or are constants
  assign lnk.cmdval   = st_r == ST_SEND;
  assign lnk.cmd      = rd_r ? CMD_READ : CMD_WRITE;
  assign lnk.address  = cadr_r;
  assign lnk.be       = be_r;
  assign lnk.wdata    = wd_r;
  assign lnk.exp_data = '0;
  assign lnk.eop      = eop_r;
  assign lnk.plen     = pk_len_r;
  assign lnk.clen     = '0;
  assign lnk.contig   = stride_r <= STR_CELL;
  assign lnk.wrap     = 1'b0;
  assign lnk.srcid    = SRC_ID;
  assign lnk.trdid    = '0;
  assign lnk.pktid    = pktid_r;
  assign lnk.str_step = STRIDE_PATTERN_EN ? stride_r : '0;
  assign lnk.str_vlen = STRIDE_PATTERN_EN ? vlen_r : '0;
  // Default acknowledge takes every response at once; else ack what is shown
  assign lnk.rspack   = default_ack_supported ? 1'b1 : lnk.rspval;

  assign rd_valid = rd_valid_r;
  assign rd_data  = rd_data_r;
  assign rd_last  = rd_last_r;
  assign rd_err   = rd_err_r;
  assign done     = done_r;
  assign tmo_err  = tmo_err_r;
endmodule

// File: core/ipc_target.sv
`timescale 1ns/1ps
module ipc_target #(
  parameter bit default_ack_supported = 1'b1,
  parameter int ACK_WAIT              = 2,
  parameter bit BASIC_VARIANT         = 1'b0
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  // Link
  ipc_link_if.tgt                          lnk,
  // User side
  input  wire logic                        hold,
  output logic                             cell_valid,
  output logic [ipc_pkg::ADDR_W-1:0]       cell_addr,
  output logic [ipc_pkg::BE_W-1:0]         cell_be,
  output logic [ipc_pkg::DATA_W-1:0]       cell_data,
  output logic                             cell_eop,
  output logic                             cell_read,
  output logic [ipc_pkg::ID_W-1:0]         cell_pktid
);
  import ipc_pkg::*;

  localparam int MAW = $clog2(MEM_WORDS);

  logic [DATA_W-1:0]  mem [MEM_WORDS];
  logic [WAIT_W-1:0]  wait_r;
  logic               rsp_r;
  logic [DATA_W-1:0]  rdata_r;
  logic               reop_r;
  logic               rerr_r;
  logic               ready;
  logic               take;
  logic               in_rng;
  logic [MAW-1:0]     idx;
  logic [DATA_W-1:0]  wmask;

  assign idx    = lnk.address[MAW+LANE_W-1:LANE_W];
  assign in_rng = lnk.address[ADDR_W-1:MAW+LANE_W] == '0;
  assign ready  = !rsp_r && !hold;
  assign lnk.cmdack = lnk.cmdval && ready &&
                      (default_ack_supported || wait_r == WAIT_W'(ACK_WAIT));
  assign take   = lnk.cmdval && lnk.cmdack;

  genvar i;
  generate
    for (i = 0; i < BE_W; i++) begin : g_lane
      assign wmask[i*BYTE_W +: BYTE_W] = {BYTE_W{lnk.be[i]}};
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wait_r <= '0;
    end else if (!lnk.cmdval || take) begin
      wait_r <= '0;
    end else if (ready && wait_r != WAIT_W'(ACK_WAIT)) begin
      wait_r <= wait_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (take && lnk.cmd == CMD_WRITE && in_rng) begin
      mem[idx] <= (mem[idx] & ~wmask) | (lnk.wdata & wmask);
    end
  end

  // One response outstanding; new cells held off until it is taken
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rsp_r   <= 1'b0;
      rdata_r <= '0;
      reop_r  <= 1'b0;
      rerr_r  <= 1'b0;
    end else if (take) begin
      rsp_r   <= 1'b1;
      rdata_r <= (lnk.cmd == CMD_READ && in_rng) ? mem[idx] : '0;
      reop_r  <= lnk.eop;
      rerr_r  <= !in_rng;
    end else if (lnk.rspack) begin
      rsp_r <= 1'b0;
    end
  end

  assign lnk.rspval = rsp_r;
  assign lnk.rdata  = rdata_r;
  assign lnk.reop   = reop_r;
  assign lnk.rerror = rerr_r;

  // Stride hints and source or thread fields are not needed here
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cell_valid <= 1'b0;
      cell_addr  <= '0;
      cell_be    <= '0;
      cell_data  <= '0;
      cell_eop   <= 1'b0;
      cell_read  <= 1'b0;
      cell_pktid <= '0;
    end else begin
      cell_valid <= take;
      if (take) begin
        cell_addr  <= lnk.address;
        cell_be    <= lnk.be;
        cell_data  <= lnk.wdata;
        cell_eop   <= lnk.eop;
        cell_read  <= lnk.cmd == CMD_READ;
        cell_pktid <= BASIC_VARIANT ? '0 : lnk.pktid;
      end
    end
  end
endmodule

// File: dv/ipc_link_properties.sv
`timescale 1ns/1ps
module ipc_link_properties #(
  parameter int TIMEOUT_CYC = 16
) (
  // Clock and reset
  input wire logic                       sys_clk,
  input wire logic                       nrst,
  // Request
  input wire logic                       cmdval,
  input wire logic                       cmdack,
  input wire logic [1:0]                 cmd,
  input wire logic [ipc_pkg::ADDR_W-1:0] address,
  input wire logic [ipc_pkg::BE_W-1:0]   be,
  input wire logic [ipc_pkg::DATA_W-1:0] wdata,
  input wire logic [ipc_pkg::DATA_W-1:0] exp_data,
  input wire logic                       eop,
  input wire logic [ipc_pkg::CLEN_W-1:0] clen,
  input wire logic                       contig,
  input wire logic                       wrap,
  input wire logic [ipc_pkg::TRD_W-1:0]  trdid,
  // Response
  input wire logic                       rspval,
  input wire logic                       reop
);
  import ipc_pkg::*;
  logic [ADDR_W-1:0] prev_a_r;
  logic              prev_v_r;
  logic              prev_c_r;
  logic [15:0]       wait_r;

  // Last accepted cell inside a packet
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prev_v_r <= 1'b0;
      prev_a_r <= '0;
      prev_c_r <= 1'b0;
    end else if (cmdval && cmdack) begin
      prev_v_r <= !eop;
      prev_a_r <= address;
      prev_c_r <= contig;
    end
  end

  // Unacknowledged cycles of the current cell
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wait_r <= 16'h0000;
    end else if (cmdval && !cmdack) begin
      wait_r <= wait_r + 16'h0001;
    end else begin
      wait_r <= 16'h0000;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  thread_zero_a: assert property (cmdval |-> trdid == 4'h0)
    else $error("thread id nonzero on a cell");
  exp_zero_a: assert property (cmdval && cmd == CMD_READ |-> exp_data == 32'h00000000)
    else $error("expected data nonzero on a read cell");
  no_wrap_a: assert property (cmdval |-> !wrap)
    else $error("wrapped packet issued");
  clen_zero_a: assert property (cmdval |-> clen == 8'h00)
    else $error("chain length nonzero");
  req_hold_a: assert property ((cmdval && !cmdack) ##1 cmdval |->
    $stable(address) && $stable(be) && $stable(wdata) && $stable(eop) && $stable(cmd))
    else $error("request fields changed before acknowledge");
  rsp_follow_a: assert property (cmdval && cmdack |=> rspval && reop == $past(eop))
    else $error("response missing or end mark mismatch");
  contig_step_a: assert property (cmdval && prev_v_r && prev_c_r |->
    address == prev_a_r + CELL_BYTES)
    else $error("contiguous packet address not consecutive");
  gap_step_a: assert property (cmdval && prev_v_r && !prev_c_r |-> address > prev_a_r)
    else $error("strided address not increasing");
  tmo_bound_a: assert property (cmdval |-> wait_r <= TIMEOUT_CYC)
    else $error("request held beyond time-out");

  cover property (cmdval && cmdack && eop);
  cover property (cmdval && !cmdack ##1 !cmdval);
  cover property (cmdval && cmdack && !contig);
  cover property (cmdval && cmdack && cmd == CMD_READ);
endmodule

// File: dv/tb_initiator_packet_chain_gen.sv
`timescale 1ns/1ps
module tb_initiator_packet_chain_gen;
  import ipc_pkg::*;
  localparam int TMO = 16;
  logic sys_clk = 1'b0, nrst = 1'b0, hold = 1'b0;
  logic req_valid = 1'b0, req_read = 1'b0, wr_valid = 1'b0;
  logic [31:0] req_addr = '0;
  logic [15:0] req_tlen = '0;
  logic [7:0] req_stride = '0, req_vlen = '0, wr_byte = '0, bc = '0;
  logic [8:0] req_plen = '0;
  logic req_ready, wr_ready, rd_valid, rd_last, rd_err, done, tmo_err;
  logic [31:0] rd_data, c_addr, c_data;
  logic [3:0] c_be;
  logic c_valid, c_eop, c_rd;
  logic [7:0] c_pk;
  int n_errors = 0, comparisons = 0;
  logic [7:0] mem [0:255];
  logic [31:0] cq_a[$], ea[$], cq_d[$], ed[$], rq_d[$];
  logic [3:0] cq_be[$], eb[$];
  logic cq_e[$], ee[$], rq_l[$], rq_e[$], cq_r[$];
  logic [7:0] cq_pk[$], epk[$], bq[$];
  logic [8:0] cq_pl[$];

  ipc_link_if lnk ();
  ipc_initiator #(.default_ack_supported(1'b1), .TIMEOUT_CYC(TMO)) ipc_initiator_inst (
    .sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
    .req_read(req_read), .req_addr(req_addr), .req_tlen(req_tlen), .req_stride(req_stride),
    .req_vlen(req_vlen), .req_plen(req_plen), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_byte(wr_byte), .rd_valid(rd_valid), .rd_data(rd_data), .rd_last(rd_last),
    .rd_err(rd_err), .done(done), .tmo_err(tmo_err), .lnk(lnk));
  ipc_target ipc_target_inst (
    .sys_clk(sys_clk), .nrst(nrst), .lnk(lnk), .hold(hold), .cell_valid(c_valid),
    .cell_addr(c_addr), .cell_be(c_be), .cell_data(c_data), .cell_eop(c_eop),
    .cell_read(c_rd), .cell_pktid(c_pk));
  ipc_link_properties #(.TIMEOUT_CYC(TMO)) ipc_link_properties_inst (
    .sys_clk(sys_clk), .nrst(nrst), .cmdval(lnk.cmdval), .cmdack(lnk.cmdack),
    .cmd(lnk.cmd), .address(lnk.address), .be(lnk.be), .wdata(lnk.wdata),
    .exp_data(lnk.exp_data), .eop(lnk.eop), .clen(lnk.clen), .contig(lnk.contig),
    .wrap(lnk.wrap), .trdid(lnk.trdid), .rspval(lnk.rspval), .reop(lnk.reop));

  always #20 sys_clk = ~sys_clk;

  // Record what crosses the link and the read return
  always @(posedge sys_clk) begin
    if (c_valid === 1'b1) begin
      cq_a.push_back(c_addr); cq_be.push_back(c_be); cq_d.push_back(c_data);
      cq_e.push_back(c_eop); cq_pk.push_back(c_pk); cq_r.push_back(c_rd);
    end
    if (lnk.cmdval === 1'b1 && lnk.cmdack === 1'b1) cq_pl.push_back(lnk.plen);
    if (rd_valid === 1'b1) begin
      rq_d.push_back(rd_data); rq_l.push_back(rd_last); rq_e.push_back(rd_err);
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic push_n(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      wr_valid = 1'b1;
      wr_byte = 8'h5A ^ bc;
      do @(posedge sys_clk); while (wr_ready !== 1'b1);
      bq.push_back(wr_byte);
      bc++;
    end
    @(negedge sys_clk);
    wr_valid = 1'b0;
  endtask

  task automatic req(input logic rd, input logic [31:0] a, input int tl, st, vl, pl);
    @(negedge sys_clk);
    req_valid = 1'b1; req_read = rd; req_addr = a; req_tlen = tl[15:0];
    req_stride = st[7:0]; req_vlen = vl[7:0]; req_plen = pl[8:0];
    @(negedge sys_clk);
    req_valid = 1'b0;
  endtask

  // Expected cells: stride on target bytes only, source packed
  task automatic exp_build(input logic [31:0] a, input int tl, st, vl, pl, input logic rd);
    logic [3:0] be;
    logic [31:0] d;
    logic [7:0] pk;
    int ln;
    bit pend;
    ea.delete(); eb.delete(); ed.delete(); ee.delete(); epk.delete();
    be = '0; d = '0; pk = '0;
    for (int k = 0; k < tl; k++) begin
      ln = (a + k) % 4;
      if (st == 0 || (k % st) < vl) begin
        be[ln] = 1'b1;
        if (!rd) mem[a + k] = bq.pop_front();
        d[8*ln +: 8] = mem[a + k];
      end
      pend = ((k + 1) % pl == 0) || (k == tl - 1);
      if (pend || ln == 3) begin
        if (be != 4'h0 || pend) begin
          ea.push_back((a + k) & 32'hFFFFFFFC); eb.push_back(be); ed.push_back(d);
          ee.push_back(pend); epk.push_back(pk);
        end
        be = '0; d = '0;
        if (pend) pk++;
      end
    end
  endtask

  task automatic run(input string nm, input logic rd, input logic [31:0] a,
                     input int tl, st, vl, pl, np);
    logic got;
    cq_a.delete(); cq_be.delete(); cq_d.delete(); cq_e.delete(); cq_pk.delete();
    cq_pl.delete(); rq_d.delete(); rq_l.delete(); rq_e.delete(); cq_r.delete();
    fork
      push_n(np);
      begin
        req(rd, a, tl, st, vl, pl);
        for (int i = 0; i < 4000 && done !== 1'b1; i++) @(negedge sys_clk);
        got = done;
      end
    join
    repeat (4) @(negedge sys_clk);
    chk("done", 1, got);
    exp_build(a, tl, st, vl, pl, rd);
    chk("cell count", ea.size(), cq_a.size());
    for (int i = 0; i < ea.size() && i < cq_a.size(); i++) begin
      chk("cell address", ea[i], cq_a[i]);
      chk("byte enables", eb[i], cq_be[i]);
      chk("end of packet", ee[i], cq_e[i]);
      chk("packet id", epk[i], cq_pk[i]);
      chk("cell read", rd, cq_r[i]);
      if (!rd) chk("write data", ed[i] & {{8{eb[i][3]}}, {8{eb[i][2]}}, {8{eb[i][1]}},
                   {8{eb[i][0]}}}, cq_d[i] & {{8{eb[i][3]}}, {8{eb[i][2]}},
                   {8{eb[i][1]}}, {8{eb[i][0]}}});
      if (rd && i < rq_d.size()) chk("read data", ed[i], rq_d[i]);
      if (rd && i < rq_d.size()) chk("read error", 0, rq_e[i]);
    end
    foreach (cq_pl[i]) chk("packet length", pl, cq_pl[i]);
    if (rd) chk("read count", ea.size(), rq_d.size());
    if (rd && rq_l.size() > 0) chk("read last", 1, rq_l[rq_l.size()-1]);
    $display("test %s finished, mismatches so far %0d", nm, n_errors);
  endtask

  task automatic t_fill_then_write();
    push_n(8);
    chk("fifo full refuses", 0, wr_ready);
    run("fifo fill then write", 1'b0, 32'h30, 8, 0, 0, 8, 0);
  endtask

  task automatic t_chain_stall();
    fork
      run("two packet chain", 1'b0, 32'h00, 32, 0, 0, 16, 32);
      begin
        repeat (14) @(negedge sys_clk);
        hold = 1'b1;
        repeat (5) @(negedge sys_clk);
        hold = 1'b0;
      end
    join
  endtask

  task automatic t_timeout();
    logic got;
    got = 1'b0;
    cq_a.delete();
    hold = 1'b1;
    req(1'b1, 32'h0, 4, 0, 0, 4);
    for (int i = 0; i < 10 * TMO && !got; i++) begin
      @(negedge sys_clk);
      got = (tmo_err === 1'b1);
    end
    hold = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("withdraw flag", 1, got);
    chk("cells on withdrawal", 0, cq_a.size());
    chk("idle after withdrawal", 1, req_ready);
    $display("test time-out finished, mismatches so far %0d", n_errors);
  endtask

  task automatic t_refused();
    logic seen;
    seen = 1'b0;
    req(1'b0, 32'h40, 0, 0, 0, 16);
    repeat (20) begin
      @(negedge sys_clk);
      seen = seen | (done === 1'b1) | (req_ready !== 1'b1);
    end
    chk("zero length ignored", 0, seen);
    $display("test zero length finished, mismatches so far %0d", n_errors);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge sys_clk);
    nrst = 1'b1;
    t_fill_then_write();
    t_chain_stall();
    run("contiguous read", 1'b1, 32'h10, 16, 0, 0, 16, 0);
    run("short stride", 1'b0, 32'h40, 16, 2, 1, 16, 8);
    run("long stride", 1'b0, 32'h80, 16, 8, 2, 16, 4);
    t_timeout();
    t_refused();
    tally_and_finish();
  end

  initial begin
    #800000;
    n_errors++;
    tally_and_finish();
  end
endmodule
